// file: logic/ubc_pkg.sv
// shared constants and types for the baud and break control block
package ubc_pkg;
    localparam int          ADR_W         = 18;
    localparam logic [15:0] IDX_MODE      = 16'hFF50;
    localparam logic [15:0] IDX_CLKSEL    = 16'hFF56;
    localparam logic [15:0] IDX_DIVIDER   = 16'hFF57;
    localparam logic [15:0] IDX_BRKCTL    = 16'hFF58;
    localparam logic [7:0]  RST_MODE      = 8'h01;
    localparam logic [3:0]  RST_CLKSEL    = 4'h0;
    localparam logic [7:0]  RST_DIVIDER   = 8'hFF;
    localparam logic [7:0]  RST_BRKCTL    = 8'h16;
    localparam int          MODE_POWER    = 7;
    localparam int          MODE_TXE      = 6;
    localparam int          MODE_RXE      = 5;
    localparam int          BC_RXSTAT     = 7;
    localparam int          BC_RXTRIG     = 6;
    localparam int          BC_TXTRIG     = 5;
    localparam int          BC_LEN_HI     = 4;
    localparam int          BC_LEN_LO     = 2;
    localparam int          BC_DIR        = 1;
    localparam int          BC_INV        = 0;
    localparam int          CLKSEL_W      = 4;
    localparam logic [3:0]  SEL_PRE_MAX   = 4'hA;
    localparam logic [3:0]  SEL_TIMER     = 4'hB;
    localparam int          PRE_W         = 10;
    localparam logic [7:0]  DIV_STEP      = 8'h01;
    localparam int          TICKS_PER_BIT = 2;
    localparam logic [5:0]  BRK_BASE_BITS = 6'h10;
    localparam logic [2:0]  BRK_LEN_TOP   = 3'h4;
    localparam logic [5:0]  BRK_WRAP_BITS = 6'h08;
    localparam int          RX_MIN_BITS   = 11;
    localparam logic [5:0]  RX_MIN_TICKS  = 6'(RX_MIN_BITS * TICKS_PER_BIT);

    typedef enum logic [2:0] {
        RX_OFF  = 3'b001,
        RX_WAIT = 3'b010,
        RX_LOW  = 3'b100
    } ubc_rx_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } ubc_tx_e;
endpackage

// file: logic/ubc_tick_if.sv
// counter and bit-rate enable pulses from the divider to the break logic
`timescale 1ns/1ns
interface ubc_tick_if;
    logic tick;
    logic bitTick;
    modport src (output tick, output bitTick);
    modport dst (input tick, input bitTick);
endinterface

// file: logic/ubc_sync.sv
// two-stage synchroniser for the serial receive pin
`timescale 1ns/1ns
module ubc_sync (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } ubc_sync_s;

    ubc_sync_s st;
    ubc_sync_s next_st;

    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    // line idles high, so reset to the idle level
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st <= 2'b11;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule

// file: logic/ubc_divider.sv
// base clock prescaler and 8-bit baud counter
`timescale 1ns/1ns
module ubc_divider (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic                          run,
    input  wire logic [ubc_pkg::CLKSEL_W-1:0]  clkSel,
    input  wire logic [7:0]                    divValue,
    input  wire logic                          timerPulse,
    ubc_tick_if.src                            tk
);
    typedef struct packed {
        logic [ubc_pkg::PRE_W-1:0] pre;
        logic [7:0]                cnt;
        logic                      half;
        logic                      tick;
        logic                      bitTick;
    } ubc_div_s;

    ubc_div_s                  st;
    ubc_div_s                  next_st;
    logic [ubc_pkg::PRE_W-1:0] mask;
    logic                      baseHit;

    always_comb begin
        mask    = ubc_pkg::PRE_W'((11'h001 << clkSel) - 11'h001);
        baseHit = 1'b0;
        if (clkSel <= ubc_pkg::SEL_PRE_MAX) begin
            baseHit = ((st.pre & mask) == mask);
        end else if (clkSel == ubc_pkg::SEL_TIMER) begin
            baseHit = timerPulse;
        end
        next_st         = st;
        next_st.tick    = 1'b0;
        next_st.bitTick = 1'b0;
        next_st.pre     = st.pre + 1'b1;
        // compare against k-1 every time, so a same-value rewrite never disturbs the count
        if (baseHit) begin
            if (st.cnt >= divValue - ubc_pkg::DIV_STEP) begin
                next_st.cnt     = '0;
                next_st.tick    = 1'b1;
                next_st.half    = ~st.half;
                next_st.bitTick = st.half;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
        // power off stops the internal clock and clears the phase
        if (!run) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tk.tick    = st.tick;
    assign tk.bitTick = st.bitTick;

    a_tick_gap: assert property (@(posedge clock) disable iff (rst)
        (st.tick && divValue >= 8'h04) |=> !st.tick [*3])
        else $error("baud counter pulses closer than k base clocks");
    a_bit_half: assert property (@(posedge clock) disable iff (rst)
        st.bitTick |-> (st.tick && !st.half))
        else $error("bit pulse not on every second counter pulse");
endmodule

// file: logic/ubc_top.sv
// baud divider and break field control with a classic Wishbone register slave
// What this block does
// - reset loads divider with all ones
// - counter output is base clock over k
// - bit rate is counter output halved
// - same-value divider rewrite never disturbs operation
// - break control register resets to 16H
// - break receive flag set while receiving
// - receive error rearms, flag stays one
// - receive trigger reads zero, self clears
// - transmit trigger reads zero, self clears
// - transmitted break length follows 3-bit field
// - break transmit end raises transmit complete
// - bit order and transmit inversion controls
// - base clock is prescaled or timer output
// - power off resets unit, enables reset circuits
`timescale 1ns/1ns
module ubc_top (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [ubc_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic                      serialRxPin,
    input  wire logic                      timerPulse,
    output logic                           serialTxPin,
    output logic                           txCompleteIrq,
    output logic                           rxBreakIrq,
    output logic                           firstBitLsb
);
    typedef struct packed {
        logic [7:0]                       mode;
        logic [ubc_pkg::CLKSEL_W-1:0]     clkSel;
        logic [7:0]                       divider;
        logic [2:0]                       brkLen;
        logic                             dir;
        logic                             inv;
        logic                             rxStatus;
        ubc_pkg::ubc_rx_e                 rxState;
        ubc_pkg::ubc_tx_e                 txState;
        logic [5:0]                       txCnt;
        logic [5:0]                       lowCnt;
        logic                             ack;
        logic [31:0]                      rdata;
        logic                             txd;
        logic                             txIrq;
        logic                             rxIrq;
    } ubc_top_s;

    localparam ubc_top_s RST_ST = '{
        mode:     ubc_pkg::RST_MODE,
        clkSel:   ubc_pkg::RST_CLKSEL,
        divider:  ubc_pkg::RST_DIVIDER,
        brkLen:   ubc_pkg::RST_BRKCTL[ubc_pkg::BC_LEN_HI:ubc_pkg::BC_LEN_LO],
        dir:      ubc_pkg::RST_BRKCTL[ubc_pkg::BC_DIR],
        inv:      ubc_pkg::RST_BRKCTL[ubc_pkg::BC_INV],
        rxStatus: ubc_pkg::RST_BRKCTL[ubc_pkg::BC_RXSTAT],
        rxState:  ubc_pkg::RX_OFF,
        txState:  ubc_pkg::TX_IDLE,
        txCnt:    6'h00,
        lowCnt:   6'h00,
        ack:      1'b0,
        rdata:    32'h0000_0000,
        txd:      1'b1,
        txIrq:    1'b0,
        rxIrq:    1'b0
    };

    ubc_top_s    st;
    ubc_top_s    next_st;
    ubc_tick_if  tk ();
    logic        rxd;
    logic [15:0] idx;
    logic        power;
    logic        txOn;
    logic        rxOn;
    logic [5:0]  lenBits;
    logic [5:0]  lenTicks;
    logic        ctlWrite;

    ubc_sync u_rx_sync (
        .clock (clock),
        .rst   (rst),
        .d     (serialRxPin),
        .q     (rxd)
    );

    ubc_divider u_divider (
        .clock      (clock),
        .rst        (rst),
        .run        (power),
        .clkSel     (st.clkSel),
        .divValue   (st.divider),
        .timerPulse (timerPulse),
        .tk         (tk.src)
    );

    assign idx   = wb_adr_i[ubc_pkg::ADR_W-1:2];
    assign power = st.mode[ubc_pkg::MODE_POWER];
    assign txOn  = power & st.mode[ubc_pkg::MODE_TXE];
    assign rxOn  = power & st.mode[ubc_pkg::MODE_RXE];
    // codes above four wrap down to the 13 to 15 bit lengths
    assign lenBits  = (st.brkLen > ubc_pkg::BRK_LEN_TOP)
                    ? 6'(ubc_pkg::BRK_BASE_BITS + {3'b000, st.brkLen} - ubc_pkg::BRK_WRAP_BITS)
                    : 6'(ubc_pkg::BRK_BASE_BITS + {3'b000, st.brkLen});
    assign ctlWrite = wb_cyc_i && wb_stb_i && !st.ack && wb_we_i && wb_sel_i[0] && idx == ubc_pkg::IDX_BRKCTL;
    assign lenTicks = 6'(lenBits * ubc_pkg::TICKS_PER_BIT);

    always_comb begin
        next_st       = st;
        next_st.ack   = 1'b0;
        next_st.txIrq = 1'b0;
        next_st.rxIrq = 1'b0;

        // break transmission: low for the programmed number of bit times
        if (st.txState == ubc_pkg::TX_SEND && tk.tick) begin
            if (st.txCnt == lenTicks - 6'h01) begin
                next_st.txState = ubc_pkg::TX_IDLE;
                next_st.txIrq   = 1'b1;
            end else begin
                next_st.txCnt = st.txCnt + 6'h01;
            end
        end

        // break reception: measure the low time in counter pulses
        case (st.rxState)
            ubc_pkg::RX_OFF: begin
            end
            ubc_pkg::RX_WAIT: begin
                if (!rxd) begin
                    next_st.rxState = ubc_pkg::RX_LOW;
                    next_st.lowCnt  = '0;
                end
            end
            ubc_pkg::RX_LOW: begin
                if (rxd) begin
                    if (st.lowCnt >= ubc_pkg::RX_MIN_TICKS) begin
                        next_st.rxState  = ubc_pkg::RX_OFF;
                        next_st.rxStatus = 1'b0;
                        next_st.rxIrq    = 1'b1;
                    end else begin
                        next_st.rxState = ubc_pkg::RX_WAIT;
                    end
                end else if (tk.tick && st.lowCnt != 6'h3F) begin
                    next_st.lowCnt = st.lowCnt + 6'h01;
                end
            end
            default: begin
                next_st.rxState = ubc_pkg::RX_OFF;
            end
        endcase

        // register slave; bus writes come after the break logic so a new trigger wins over a finishing run
        if (wb_cyc_i && wb_stb_i && !st.ack) begin
            next_st.ack   = 1'b1;
            next_st.rdata = '0;
            case (idx)
                ubc_pkg::IDX_MODE: begin
                    next_st.rdata[7:0] = st.mode;
                end
                ubc_pkg::IDX_CLKSEL: begin
                    next_st.rdata[ubc_pkg::CLKSEL_W-1:0] = st.clkSel;
                end
                ubc_pkg::IDX_DIVIDER: begin
                    next_st.rdata[7:0] = st.divider;
                end
                ubc_pkg::IDX_BRKCTL: begin
                    next_st.rdata[7:0] = {st.rxStatus, 2'b00, st.brkLen, st.dir, st.inv};
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
            if (wb_we_i && wb_sel_i[0]) begin
                case (idx)
                    ubc_pkg::IDX_MODE: begin
                        next_st.mode = wb_dat_i[7:0];
                    end
                    ubc_pkg::IDX_CLKSEL: begin
                        next_st.clkSel = wb_dat_i[ubc_pkg::CLKSEL_W-1:0];
                    end
                    ubc_pkg::IDX_DIVIDER: begin
                        next_st.divider = wb_dat_i[7:0];
                    end
                    ubc_pkg::IDX_BRKCTL: begin
                        next_st.brkLen = wb_dat_i[ubc_pkg::BC_LEN_HI:ubc_pkg::BC_LEN_LO];
                        next_st.dir    = wb_dat_i[ubc_pkg::BC_DIR];
                        next_st.inv    = wb_dat_i[ubc_pkg::BC_INV];
                        // a one restarts a running break, which is why refreshes must write zero
                        if (wb_dat_i[ubc_pkg::BC_RXTRIG] && rxOn) begin
                            next_st.rxState  = ubc_pkg::RX_WAIT;
                            next_st.rxStatus = 1'b1;
                        end
                        if (wb_dat_i[ubc_pkg::BC_TXTRIG] && txOn) begin
                            next_st.txState = ubc_pkg::TX_SEND;
                            next_st.txCnt   = '0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // disabling a direction resets its circuit on the next edge
        if (!txOn) begin
            next_st.txState = ubc_pkg::TX_IDLE;
            next_st.txCnt   = '0;
        end
        if (!rxOn) begin
            next_st.rxState  = ubc_pkg::RX_OFF;
            next_st.rxStatus = 1'b0;
        end

        // powered down the line sits high whatever the inversion
        next_st.txd = power ? ((next_st.txState != ubc_pkg::TX_SEND) ^ next_st.inv) : 1'b1;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st <= RST_ST;
        end else begin
            st <= next_st;
        end
    end

    assign wb_dat_o      = st.rdata;
    assign wb_ack_o      = st.ack;
    assign serialTxPin   = st.txd;
    assign txCompleteIrq = st.txIrq;
    assign rxBreakIrq    = st.rxIrq;
    assign firstBitLsb   = st.dir;

    a_div_reset: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> (st.divider == 8'hFF))
        else $error("divider not all ones after reset");

    a_ctl_reset: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> ({st.brkLen, st.dir, st.inv} == 5'h16 && !st.rxStatus))
        else $error("break control not 16H after reset");

    a_trig_readzero: assert property (@(posedge clock) disable iff (rst)
        (st.ack && !wb_we_i && idx == ubc_pkg::IDX_BRKCTL) |-> (st.rdata[6:5] == 2'b00))
        else $error("trigger bit read back as one");

    a_tx_done_irq: assert property (@(posedge clock) disable iff (rst)
        st.txIrq |-> ($past(st.txState) == ubc_pkg::TX_SEND && $past(tk.tick)))
        else $error("transmit complete without a finishing break");

    a_tx_length: assert property (@(posedge clock) disable iff (rst)
        (st.txState == ubc_pkg::TX_SEND && tk.tick && st.txCnt == lenTicks - 6'h01)
        |=> (st.txIrq && st.txState == ubc_pkg::TX_IDLE))
        else $error("break not ended at programmed length");

    a_txd_break: assert property (@(posedge clock) disable iff (rst)
        (st.txState == ubc_pkg::TX_SEND && power) |-> (serialTxPin == st.inv))
        else $error("break level wrong for inversion setting");

    a_tx_low_hold: assert property (@(posedge clock) disable iff (rst)
        (st.txState == ubc_pkg::TX_SEND && !tk.tick && txOn) |=> (st.txState == ubc_pkg::TX_SEND))
        else $error("break ended between counter pulses");

    a_tx_trig_start: assert property (@(posedge clock) disable iff (rst)
        (ctlWrite && wb_dat_i[ubc_pkg::BC_TXTRIG] && txOn) |=> (st.txState == ubc_pkg::TX_SEND && serialTxPin == st.inv))
        else $error("accepted break trigger did not start");

    a_tx_trig_drop: assert property (@(posedge clock) disable iff (rst)
        (ctlWrite && wb_dat_i[ubc_pkg::BC_TXTRIG] && !txOn) |=> (st.txState == ubc_pkg::TX_IDLE))
        else $error("break trigger taken while disabled");

    a_txirq_single: assert property (@(posedge clock) disable iff (rst)
        st.txIrq |=> !st.txIrq)
        else $error("transmit complete longer than one cycle");

    a_tx_off_idle: assert property (@(posedge clock) disable iff (rst)
        !txOn |=> (st.txState == ubc_pkg::TX_IDLE && st.txCnt == 6'h00))
        else $error("transmit circuit not reset when disabled");

    a_power_idle: assert property (@(posedge clock) disable iff (rst)
        !power |=> serialTxPin)
        else $error("line not high while powered down");

    a_rx_error_hold: assert property (@(posedge clock) disable iff (rst)
        (st.rxState == ubc_pkg::RX_LOW && rxd && st.lowCnt < ubc_pkg::RX_MIN_TICKS && rxOn && !st.ack)
        |=> (st.rxStatus && st.rxState == ubc_pkg::RX_WAIT))
        else $error("short break did not rearm reception");

    a_rx_trig_arm: assert property (@(posedge clock) disable iff (rst)
        (ctlWrite && wb_dat_i[ubc_pkg::BC_RXTRIG] && rxOn) |=> (st.rxStatus && st.rxState == ubc_pkg::RX_WAIT))
        else $error("receive trigger did not arm");

    a_rx_state_flag: assert property (@(posedge clock) disable iff (rst)
        (st.rxState != ubc_pkg::RX_OFF) |-> st.rxStatus)
        else $error("reception running with status clear");

    a_rx_done_clear: assert property (@(posedge clock) disable iff (rst)
        st.rxIrq |-> (!st.rxStatus && $past(st.lowCnt) >= ubc_pkg::RX_MIN_TICKS))
        else $error("break received but status still set");

    a_rx_off_clear: assert property (@(posedge clock) disable iff (rst)
        !rxOn |=> !st.rxStatus)
        else $error("status held with reception off");

    a_rx_off_idle: assert property (@(posedge clock) disable iff (rst)
        !rxOn |=> (st.rxState == ubc_pkg::RX_OFF))
        else $error("receive circuit not reset when disabled");

    // bus handshake
    a_ack_latency: assert property (@(posedge clock) disable iff (rst)
        (wb_cyc_i && wb_stb_i && !st.ack) |=> st.ack)
        else $error("bus request not answered next cycle");

    a_ack_single: assert property (@(posedge clock) disable iff (rst)
        st.ack |=> !st.ack)
        else $error("bus ack longer than one cycle");

    a_rdata_upper: assert property (@(posedge clock) disable iff (rst)
        st.ack |-> (st.rdata[31:8] == 24'h000000))
        else $error("read data upper bits not zero");

    c_tx_break: cover property (@(posedge clock) disable iff (rst) st.txIrq);
    c_rx_break: cover property (@(posedge clock) disable iff (rst) st.rxIrq);
    c_rx_error: cover property (@(posedge clock) disable iff (rst)
        st.rxState == ubc_pkg::RX_LOW ##1 st.rxState == ubc_pkg::RX_WAIT);
    c_inverted: cover property (@(posedge clock) disable iff (rst)
        st.txState == ubc_pkg::TX_SEND && st.inv);
    c_len_twenty: cover property (@(posedge clock) disable iff (rst)
        st.txIrq && st.brkLen == ubc_pkg::BRK_LEN_TOP);
endmodule

// file: dv/ubc_remote_node.sv
// remote serial node model: sends break fields and times the ones it receives
`timescale 1ns/1ns
module ubc_remote_node (
    input  wire logic clock,
    input  wire logic serialTxPin,
    input  wire logic txInvert,
    output logic      serialRxPin
);
    int lowCycles = 0;

    // the line idles at mark level when released, like a pulled-up bus
    initial serialRxPin = 1'b1;

    // counts every cycle the line sits at break level; callers take differences
    always @(posedge clock) begin
        if (serialTxPin === txInvert) begin
            lowCycles <= lowCycles + 1;
        end
    end

    task automatic sendBreak(input int cycles);
        @(posedge clock);
        serialRxPin <= 1'b0;
        repeat (cycles) @(posedge clock);
        serialRxPin <= 1'b1;
    endtask
endmodule

// file: dv/tb_top.sv
// self-checking bench for the baud divider and break control block
`timescale 1ns/1ns
module tb_top;
    logic                      clock;
    logic                      rst;
    logic                      wbCyc;
    logic                      wbStb;
    logic                      wbWe;
    logic [ubc_pkg::ADR_W-1:0] wbAdr;
    logic [3:0]                wbSel;
    logic [31:0]               wbDatI;
    logic [31:0]               wbDatO;
    logic [31:0]               rd;
    logic                      wbAck;
    logic                      serialRxPin;
    logic                      serialTxPin;
    logic                      timerPulse = 1'b0;
    logic                      txCompleteIrq;
    logic                      rxBreakIrq;
    logic                      firstBitLsb;
    logic                      txInvert = 1'b0;
    logic                      dirBit   = 1'b1;
    int                        nErrors  = 0;
    int                        testsRun = 0;
    int                        irqSeen  = 0;
    int                        rxSeen   = 0;

    ubc_top uut (
        .clock(clock), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .serialRxPin(serialRxPin), .timerPulse(timerPulse),
        .serialTxPin(serialTxPin), .txCompleteIrq(txCompleteIrq), .rxBreakIrq(rxBreakIrq),
        .firstBitLsb(firstBitLsb)
    );

    ubc_remote_node remote (
        .clock(clock), .serialTxPin(serialTxPin), .txInvert(txInvert), .serialRxPin(serialRxPin)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // timer base: a one-cycle pulse every second clock
    always @(posedge clock) begin
        timerPulse <= ~timerPulse;
        if (txCompleteIrq === 1'b1) irqSeen <= irqSeen + 1;
        if (rxBreakIrq === 1'b1) rxSeen <= rxSeen + 1;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one classic cycle; ack and data are taken at the rising edge that sees ack, and released there
    task automatic wbCycle(input logic [15:0] idx, input logic we, input logic [7:0] d, output logic [31:0] q);
        @(posedge clock);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= {idx, 2'h0};
        wbSel  <= 4'hF;
        wbDatI <= {24'h000000, d};
        do begin
            @(posedge clock);
        end while (wbAck !== 1'b1);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        wbCycle(idx, 1'b1, d, rd);
    endtask

    task automatic rdChk(input logic [15:0] idx, input logic [31:0] exp, input string what);
        wbCycle(idx, 1'b0, 8'h00, rd);
        chk(rd, exp, what);
    endtask

    // pp is clocks per counter pulse; a bit spans two pulses
    task automatic txBreak(input logic [2:0] code, input int pp, input bit refresh);
        int bits = (code >= 3'h5) ? int'(code) + 8 : int'(code) + 16;
        int base = remote.lowCycles;
        int irq0 = irqSeen;
        int cnt;
        int n;
        wr(ubc_pkg::IDX_BRKCTL, {2'h0, 1'h1, code, dirBit, txInvert});
        if (refresh) begin
            wr(ubc_pkg::IDX_DIVIDER, 8'h04);
            wr(ubc_pkg::IDX_BRKCTL, {3'h0, code, dirBit, txInvert});
        end
        for (n = 0; n < 2 * bits * pp + 60 && irqSeen == irq0; n++) @(posedge clock);
        repeat (2) @(posedge clock);
        cnt = remote.lowCycles - base;
        chk(irqSeen - irq0, 32'h1, "break end event count");
        chk(32'(cnt >= (2 * bits - 1) * pp && cnt <= 2 * bits * pp + 2), 32'h1, "break length");
        rdChk(ubc_pkg::IDX_BRKCTL, {27'h0, code, dirBit, txInvert}, "trigger reads zero");
    endtask

    initial begin
        rst    = 1'b1;
        wbCyc  = 1'b0;
        wbStb  = 1'b0;
        wbWe   = 1'b0;
        wbAdr  = '0;
        wbSel  = 4'h0;
        wbDatI = 32'h0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rdChk(ubc_pkg::IDX_MODE, 32'h01, "mode reset");
        rdChk(ubc_pkg::IDX_CLKSEL, 32'h00, "clock select reset");
        rdChk(ubc_pkg::IDX_DIVIDER, 32'hFF, "divider reset");
        rdChk(ubc_pkg::IDX_BRKCTL, 32'h16, "break control reset");
        chk({31'h0, firstBitLsb}, 32'h1, "reset bit order");
        rdChk(16'h0000, 32'h0, "unmapped read");
        wr(ubc_pkg::IDX_DIVIDER, 8'h04);
        rdChk(ubc_pkg::IDX_DIVIDER, 32'h04, "divider write");
        // trigger without power must be ignored
        wr(ubc_pkg::IDX_MODE, 8'h40);
        wr(ubc_pkg::IDX_BRKCTL, 8'h36);
        repeat (20) @(posedge clock);
        chk({31'h0, serialTxPin}, 32'h1, "unpowered line idle");
        chk(irqSeen, 32'h0, "unpowered no event");
        wr(ubc_pkg::IDX_MODE, 8'hC0);
        for (int c = 0; c < 8; c++) txBreak(3'(c), 4, c == 0);
        wr(ubc_pkg::IDX_MODE, 8'h80);
        txInvert = 1'b1;
        dirBit   = 1'b0;
        wr(ubc_pkg::IDX_BRKCTL, 8'h15);
        repeat (2) @(posedge clock);
        chk({31'h0, firstBitLsb}, 32'h0, "msb first selected");
        wr(ubc_pkg::IDX_MODE, 8'hC0);
        txBreak(3'h5, 4, 1'b0);
        wr(ubc_pkg::IDX_MODE, 8'h00);
        txInvert = 1'b0;
        dirBit   = 1'b1;
        wr(ubc_pkg::IDX_BRKCTL, 8'h16);
        wr(ubc_pkg::IDX_CLKSEL, 8'h01);
        wr(ubc_pkg::IDX_MODE, 8'hC0);
        txBreak(3'h5, 8, 1'b0);
        wr(ubc_pkg::IDX_MODE, 8'h00);
        wr(ubc_pkg::IDX_CLKSEL, 8'h0B);
        wr(ubc_pkg::IDX_MODE, 8'hC0);
        txBreak(3'h5, 8, 1'b0);
        wr(ubc_pkg::IDX_MODE, 8'h00);
        wr(ubc_pkg::IDX_CLKSEL, 8'h00);
        wr(ubc_pkg::IDX_MODE, 8'hA0);
        wr(ubc_pkg::IDX_BRKCTL, 8'h56);
        rdChk(ubc_pkg::IDX_BRKCTL, 32'h96, "receive armed");
        remote.sendBreak(80);
        repeat (10) @(posedge clock);
        rdChk(ubc_pkg::IDX_BRKCTL, 32'h96, "short break rearms");
        chk(rxSeen, 32'h0, "short break no event");
        remote.sendBreak(96);
        repeat (10) @(posedge clock);
        chk(rxSeen, 32'h1, "break received event");
        rdChk(ubc_pkg::IDX_BRKCTL, 32'h16, "receive done clears");
        wr(ubc_pkg::IDX_BRKCTL, 8'h56);
        rdChk(ubc_pkg::IDX_BRKCTL, 32'h96, "rearm sets status");
        wr(ubc_pkg::IDX_MODE, 8'h80);
        rdChk(ubc_pkg::IDX_BRKCTL, 32'h16, "disable clears status");
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clock);
        nErrors++;
        stop_test();
    end
endmodule
